// >>> src/rx_signal_qualifier.sv
/*
 * Receive qualifier: sync gating, RSSI readout, carrier sense, TX-if-clear
 * and the radio state register, with a classic Wishbone register slave.
 * Assumes demodulator, front end and packet handler share clk_i.
 */
// The Wishbone register port and the address map were chosen for this implementation.
// Contract
// - With sync required, no FIFO writes or filtering before sync.
// - Low mode bits: none, 15 of 16, 16 of 16, 30 of 32.
// - Top mode bit also demands carrier detect before reception.
// - RSSI readout tracks until sync, then frozen until next RX entry.
// - RSSI is signed two's complement, half dB per step.
// - RSSI updates at twice bandwidth over eight times two^avg length.
// - Append option writes final packet RSSI as first status byte.
// - Absolute carrier detect above threshold, released below with hysteresis.
// - Relative carrier detect on rise or fall by step between samples; here a rise by the step sets it and a fall by the step clears it.
// - Relative step disabled or 6, 10 or 14 dB.
// - Absolute offset shifts threshold by plus or minus 7 dB; the 4-bit signed offset here spans -8 to +7 dB.
// - Carrier detect on general output at select 14 and status bit.
// - Clear-channel indication on general output at select 0x09.
// - Transmit strobes in RX succeed only when channel is clear.
// - A refused transmit strobe is forgotten; host must retry.
// - Clear check: always, RSSI low, no packet, or both.
// - State changes on strobes and on internal events like underflow.
// - Radio state code readable in the radio state register.
`timescale 1ns/1ps
module rx_signal_qualifier import rxq_pkg::*; (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Wishbone slave
   input  wire logic             cyc_i,
   input  wire logic             stb_i,
   input  wire logic             we_i,
   input  wire logic [7:0]       adr_i,
   input  wire logic [3:0]       sel_i,
   input  wire logic [31:0]      dat_i,
   output logic      [31:0]      dat_o,
   output logic                  ack_o,
   // Front end and demodulator
   input  wire logic [7:0]       rssi_raw_i,
   input  wire logic             sync15_i,
   input  wire logic             sync16_i,
   input  wire logic             sync30_i,
   input  wire logic             rx_byte_valid_i,
   input  wire logic [7:0]       rx_byte_i,
   input  wire logic             pkt_end_i,
   // Transmit path events
   input  wire logic             tx_underflow_i,
   input  wire logic             tx_done_i,
   // Receive FIFO write side
   output logic                  fifo_wr_o,
   output logic      [7:0]       fifo_data_o,
   output logic                  filter_en_o,
   // Gain caps and general outputs
   output logic      [2:0]       lna_gain_cap_o,
   output logic      [1:0]       vga_gain_cap_o,
   output logic                  gpo0_o,
   output logic                  gpo1_o
);
   radio_state_t state;
   radio_state_t next_state;
   logic [2:0]   sync_qualifier_mode;
   logic [1:0]   rssi_avg_len;
   logic [3:0]   cs_abs_offset;
   logic [1:0]   cs_rel_step;
   logic [7:0]   cs_base;
   logic         status_append_en;
   logic [5:0]   gpo0_select;
   logic [5:0]   gpo1_select;
   logic [1:0]   clear_check_mode;
   logic         bus_req;
   logic         bus_wr;
   logic [7:0]   reg_adr;
   logic         rx_stb;
   logic         tx_stb;
   logic         fstx_stb;
   logic         idle_stb;
   logic         rx_entry;
   logic         sync_found;
   logic         rssi_hold;
   logic         carrier_detect;
   logic         clear_channel;
   logic         rx_open;
   logic         sync_accept;
   logic         append_now;
   logic         in_rx;
   logic [7:0]   rssi_now;
   logic [7:0]   rssi_prev;
   logic [7:0]   rssi_read;
   logic         rssi_tick;

   function automatic logic sync_hit(input logic [1:0] m, input logic h15,
                                     input logic h16, input logic h30);
      unique case (m)
         SYNC_15: sync_hit = h15 || h16;
         SYNC_16: sync_hit = h16;
         SYNC_30: sync_hit = h30;
         default: sync_hit = 1'b0;
      endcase
   endfunction

   function automatic logic [4:0] state_code(input radio_state_t s);
      unique case (s)
         ST_IDLE:  state_code = CODE_IDLE;
         ST_RX:    state_code = CODE_RX;
         ST_TX:    state_code = CODE_TX;
         ST_FSTX:  state_code = CODE_FSTX;
         ST_UFLOW: state_code = CODE_UFLOW;
         default:  state_code = CODE_IDLE;
      endcase
   endfunction

   // Bus decode: one wait state, ack pulses for one cycle
   assign bus_req = cyc_i && stb_i && !ack_o;
   assign bus_wr  = bus_req && we_i && sel_i[0];
   assign reg_adr = {adr_i[7:2], 2'b00};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= bus_req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_qualifier_mode <= RST_SYNC_MODE;
         rssi_avg_len        <= '0;
         cs_abs_offset       <= '0;
         cs_rel_step         <= '0;
         lna_gain_cap_o      <= '0;
         vga_gain_cap_o      <= '0;
         cs_base             <= RST_CS_BASE;
         status_append_en    <= 1'b0;
         gpo0_select         <= RST_PIN_CFG;
         gpo1_select         <= RST_PIN_CFG;
         clear_check_mode    <= CCA_ALWAYS;
      end else if (bus_wr) begin
         unique case (reg_adr)
            OFS_MODEM_CONFIG2: sync_qualifier_mode <= dat_i[2:0];
            OFS_GAIN_CTRL0:    rssi_avg_len        <= dat_i[1:0];
            OFS_GAIN_CTRL1: begin
               cs_abs_offset <= dat_i[3:0];
               cs_rel_step   <= dat_i[5:4];
            end
            OFS_GAIN_CTRL2: begin
               lna_gain_cap_o <= dat_i[2:0];
               vga_gain_cap_o <= dat_i[4:3];
            end
            OFS_CS_BASE:       cs_base          <= dat_i[7:0];
            OFS_PKT_CTRL1_A:   status_append_en <= dat_i[0];
            OFS_PIN_CFG0:      gpo0_select      <= dat_i[5:0];
            OFS_PIN_CFG1:      gpo1_select      <= dat_i[5:0];
            OFS_RADIO_CTRL1:   clear_check_mode <= dat_i[1:0];
            default: ;
         endcase
      end
   end

   // Command strobes are one-cycle pulses from a write to the command word
   assign rx_stb   = bus_wr && reg_adr == OFS_COMMAND && dat_i[CMD_RX];
   assign tx_stb   = bus_wr && reg_adr == OFS_COMMAND && dat_i[CMD_TX];
   assign fstx_stb = bus_wr && reg_adr == OFS_COMMAND && dat_i[CMD_FSTX];
   assign idle_stb = bus_wr && reg_adr == OFS_COMMAND && dat_i[CMD_IDLE];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= '0;
      end else if (bus_req) begin
         unique case (reg_adr)
            OFS_MODEM_CONFIG2: dat_o <= {29'h0, sync_qualifier_mode};
            OFS_GAIN_CTRL0:    dat_o <= {30'h0, rssi_avg_len};
            OFS_GAIN_CTRL1:    dat_o <= {26'h0, cs_rel_step, cs_abs_offset};
            OFS_GAIN_CTRL2:    dat_o <= {27'h0, vga_gain_cap_o, lna_gain_cap_o};
            OFS_CS_BASE:       dat_o <= {24'h0, cs_base};
            OFS_PKT_CTRL1_A:   dat_o <= {31'h0, status_append_en};
            OFS_PIN_CFG0:      dat_o <= {26'h0, gpo0_select};
            OFS_PIN_CFG1:      dat_o <= {26'h0, gpo1_select};
            OFS_RADIO_CTRL1:   dat_o <= {30'h0, clear_check_mode};
            OFS_RSSI:          dat_o <= {24'h0, rssi_read};
            OFS_PKT_STATE:     dat_o <= {27'h0, gpo1_o, gpo0_o, sync_found,
                                         clear_channel, carrier_detect};
            OFS_RADIO_STATE:   dat_o <= {27'h0, state_code(state)};
            default:           dat_o <= '0;
         endcase
      end
   end

   // Clear channel decision
   always_comb begin
      unique case (clear_check_mode)
         CCA_ALWAYS: clear_channel = 1'b1;
         CCA_RSSI:   clear_channel = !carrier_detect;
         CCA_NOPKT:  clear_channel = !sync_found;
         CCA_BOTH:   clear_channel = !carrier_detect && !sync_found;
      endcase
   end

   // Refused strobes leave no trace, so a refused strobe causes no later transition
   always_comb begin
      next_state = state;
      if (idle_stb) begin
         next_state = ST_IDLE;
      end else if (rx_stb) begin
         next_state = ST_RX;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (tx_stb) next_state = ST_TX;
               else if (fstx_stb) next_state = ST_FSTX;
            end
            ST_RX: begin
               if (tx_stb && clear_channel) next_state = ST_TX;
               else if (fstx_stb && clear_channel) next_state = ST_FSTX;
            end
            ST_FSTX: begin
               if (tx_stb) next_state = ST_TX;
            end
            ST_TX: begin
               if (tx_underflow_i) next_state = ST_UFLOW;
               else if (tx_done_i) next_state = ST_IDLE;
            end
            ST_UFLOW: ;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   assign in_rx    = (state == ST_RX);
   assign rx_entry = rx_stb;

   // Sync search and packet-in-progress flag
   assign sync_accept = in_rx && !sync_found && sync_qualifier_mode[1:0] != SYNC_NONE
                        && sync_hit(sync_qualifier_mode[1:0], sync15_i, sync16_i, sync30_i)
                        && (!sync_qualifier_mode[SYNC_CS_BIT] || carrier_detect);

   always_ff @(posedge clk_i) begin
      if (rst_i || rx_entry || !in_rx || (pkt_end_i && !sync_accept)) begin
         sync_found <= 1'b0;
      end else if (sync_accept) begin
         sync_found <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || rx_entry) begin
         rssi_hold <= 1'b0;
      end else if (sync_accept) begin
         rssi_hold <= 1'b1;
      end
   end

   assign rx_open = in_rx && (sync_qualifier_mode[1:0] == SYNC_NONE ?
                    (!sync_qualifier_mode[SYNC_CS_BIT] || carrier_detect)
                    : sync_found);
   assign append_now = in_rx && pkt_end_i && status_append_en && rx_open;

   // Status byte takes priority over a payload byte in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fifo_wr_o   <= 1'b0;
         fifo_data_o <= 8'h00;
         filter_en_o <= 1'b0;
      end else begin
         fifo_wr_o   <= append_now || (rx_byte_valid_i && rx_open);
         fifo_data_o <= append_now ? rssi_now : rx_byte_i;
         filter_en_o <= rx_open;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gpo0_o <= 1'b0;
         gpo1_o <= 1'b0;
      end else begin
         gpo0_o <= gpo0_select == GPO_SEL_CS ? carrier_detect :
                   gpo0_select == GPO_SEL_CCA && clear_channel;
         gpo1_o <= gpo1_select == GPO_SEL_CS ? carrier_detect :
                   gpo1_select == GPO_SEL_CCA && clear_channel;
      end
   end

   rssi_capture u_rssi (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .rx_active_i (in_rx),
      .avg_len_i   (rssi_avg_len),
      .hold_i      (rssi_hold),
      .rssi_raw_i  (rssi_raw_i),
      .rssi_now_o  (rssi_now),
      .rssi_prev_o (rssi_prev),
      .rssi_read_o (rssi_read),
      .tick_o      (rssi_tick)
   );

   carrier_sense u_cs (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .rx_active_i  (in_rx),
      .tick_i       (rssi_tick),
      .rssi_now_i   (rssi_now),
      .rssi_prev_i  (rssi_prev),
      .base_thr_i   (cs_base),
      .abs_offset_i (cs_abs_offset),
      .rel_step_i   (cs_rel_step),
      .cs_o         (carrier_detect)
   );

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sync_gate_a:
      assert property (fifo_wr_o && !$past(append_now) |-> $past(rx_open))
      else $error("FIFO written while reception is gated");

   mode_none_a:
      assert property (in_rx && sync_qualifier_mode == 3'h0 |-> rx_open)
      else $error("Mode without sync requirement is gated");

   cs_qual_a:
      assert property (rx_open && sync_qualifier_mode[SYNC_CS_BIT]
                       && sync_qualifier_mode[1:0] == SYNC_NONE |-> carrier_detect)
      else $error("Reception open without carrier detect");

   rssi_freeze_a:
      assert property (rssi_hold |=> $stable(rssi_read))
      else $error("RSSI readout changed while frozen");

   append_byte_a:
      assert property (append_now |=> fifo_wr_o && fifo_data_o == $past(rssi_now))
      else $error("Status byte not the final RSSI");

   gpo_cs_a:
      assert property (gpo0_select == GPO_SEL_CS |=> gpo0_o == $past(carrier_detect))
      else $error("General output does not follow carrier detect");

   gpo_cca_a:
      assert property (gpo1_select == GPO_SEL_CCA |=> gpo1_o == $past(clear_channel))
      else $error("General output does not follow clear channel");

   tx_refuse_a:
      assert property (in_rx && (tx_stb || fstx_stb) && !clear_channel
                       && !rx_stb && !idle_stb |=> state == ST_RX)
      else $error("Transmit strobe accepted on busy channel");

   no_retry_a:
      assert property (in_rx && !tx_stb && !fstx_stb && !idle_stb |=> state == ST_RX)
      else $error("Left receive without a strobe");

   underflow_a:
      assert property (state == ST_TX && tx_underflow_i && !rx_stb && !idle_stb
                       |=> state == ST_UFLOW ##1 (state == ST_UFLOW || $past(rx_stb || idle_stb)))
      else $error("Underflow not entered or not held");
endmodule // rx_signal_qualifier

// >>> src/rxq_pkg.sv
/*
 * Constants, field layouts and types for the receive qualifier block.
 * Assumes a 10 MHz system clock and classic Wishbone register access.
 */
package rxq_pkg;
   // Clock and RSSI update timing
   localparam int CLK_KHZ       = 10000;
   localparam int CHAN_BW_KHZ   = 100;
   localparam int RSSI_DIV      = 8;
   localparam int RSSI_BASE_CYC = CLK_KHZ * RSSI_DIV / (2 * CHAN_BW_KHZ);
   localparam int DIV_W         = 12;

   // Register byte offsets
   localparam logic [7:0] OFS_MODEM_CONFIG2 = 8'h00;
   localparam logic [7:0] OFS_GAIN_CTRL0    = 8'h04;
   localparam logic [7:0] OFS_GAIN_CTRL1    = 8'h08;
   localparam logic [7:0] OFS_GAIN_CTRL2    = 8'h0c;
   localparam logic [7:0] OFS_CS_BASE       = 8'h10;
   localparam logic [7:0] OFS_PKT_CTRL1_A   = 8'h14;
   localparam logic [7:0] OFS_PIN_CFG0      = 8'h18;
   localparam logic [7:0] OFS_PIN_CFG1      = 8'h1c;
   localparam logic [7:0] OFS_RADIO_CTRL1   = 8'h20;
   localparam logic [7:0] OFS_COMMAND       = 8'h24;
   localparam logic [7:0] OFS_RSSI          = 8'h28;
   localparam logic [7:0] OFS_PKT_STATE     = 8'h2c;
   localparam logic [7:0] OFS_RADIO_STATE   = 8'h30;

   // Reset values
   localparam logic [2:0] RST_SYNC_MODE = 3'h2;
   localparam logic [7:0] RST_CS_BASE   = 8'hb0;
   localparam logic [5:0] RST_PIN_CFG   = 6'h00;

   // Command register bits
   localparam int CMD_RX    = 0;
   localparam int CMD_TX    = 1;
   localparam int CMD_FSTX  = 2;
   localparam int CMD_IDLE  = 3;

   // Sync requirement codes (low two bits of sync_qualifier_mode)
   localparam logic [1:0] SYNC_NONE = 2'h0;
   localparam logic [1:0] SYNC_15   = 2'h1;
   localparam logic [1:0] SYNC_16   = 2'h2;
   localparam logic [1:0] SYNC_30   = 2'h3;
   localparam int         SYNC_CS_BIT = 2;

   // Clear check modes
   localparam logic [1:0] CCA_ALWAYS = 2'h0;
   localparam logic [1:0] CCA_RSSI   = 2'h1;
   localparam logic [1:0] CCA_NOPKT  = 2'h2;
   localparam logic [1:0] CCA_BOTH   = 2'h3;

   // General output selections
   localparam logic [5:0] GPO_SEL_CCA = 6'h09;
   localparam logic [5:0] GPO_SEL_CS  = 6'h0e;

   // Thresholds in half-dB steps, 10-bit signed arithmetic
   localparam logic signed [9:0] CS_HYST   = 10'sh002;
   localparam logic signed [9:0] REL_6DB   = 10'sh00c;
   localparam logic signed [9:0] REL_10DB  = 10'sh014;
   localparam logic signed [9:0] REL_14DB  = 10'sh01c;

   // Numeric state codes, values arbitrary
   localparam logic [4:0] CODE_IDLE  = 5'h01;
   localparam logic [4:0] CODE_RX    = 5'h02;
   localparam logic [4:0] CODE_TX    = 5'h03;
   localparam logic [4:0] CODE_FSTX  = 5'h04;
   localparam logic [4:0] CODE_UFLOW = 5'h05;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_RX    = 5'b00010,
      ST_TX    = 5'b00100,
      ST_FSTX  = 5'b01000,
      ST_UFLOW = 5'b10000
   } radio_state_t;
endpackage

// >>> src/rssi_capture.sv
/*
 * RSSI update divider, live sample, previous sample and frozen readout.
 * Assumes rssi_raw_i comes from same-clock front-end logic.
 */
`timescale 1ns/1ps
module rssi_capture import rxq_pkg::*; (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Control
   input  wire logic             rx_active_i,
   input  wire logic [1:0]       avg_len_i,
   input  wire logic             hold_i,
   // Samples
   input  wire logic [7:0]       rssi_raw_i,
   output logic      [7:0]       rssi_now_o,
   output logic      [7:0]       rssi_prev_o,
   output logic      [7:0]       rssi_read_o,
   output logic                  tick_o
);
   logic [DIV_W-1:0] div_cnt;
   logic [DIV_W-1:0] div_last;

   assign div_last = DIV_W'((RSSI_BASE_CYC << avg_len_i) - 1);
   assign tick_o   = rx_active_i && (div_cnt == div_last);

   always_ff @(posedge clk_i) begin
      if (rst_i || !rx_active_i || tick_o) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rssi_now_o  <= 8'h00;
         rssi_prev_o <= 8'h00;
      end else if (tick_o) begin
         rssi_prev_o <= rssi_now_o;
         rssi_now_o  <= rssi_raw_i;
      end
   end

   // Readout stops once sync is seen; live sample keeps feeding carrier sense
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rssi_read_o <= 8'h00;
      end else if (tick_o && !hold_i) begin
         rssi_read_o <= rssi_raw_i;
      end
   end
endmodule // rssi_capture

// >>> src/carrier_sense.sv
/*
 * Absolute and relative carrier sense on each RSSI update.
 * Assumes samples and tick from rssi_capture on the same clock.
 */
`timescale 1ns/1ps
module carrier_sense import rxq_pkg::*; (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Samples
   input  wire logic             rx_active_i,
   input  wire logic             tick_i,
   input  wire logic [7:0]       rssi_now_i,
   input  wire logic [7:0]       rssi_prev_i,
   // Settings
   input  wire logic [7:0]       base_thr_i,
   input  wire logic [3:0]       abs_offset_i,
   input  wire logic [1:0]       rel_step_i,
   // Result
   output logic                  cs_o
);
   logic signed [9:0] thr;
   logic signed [9:0] diff;
   logic signed [9:0] step;
   logic              abs_cs;
   logic              rel_cs;
   logic              fresh;

   function automatic logic signed [9:0] step_of(input logic [1:0] code);
      unique case (code)
         2'h1:    step_of = REL_6DB;
         2'h2:    step_of = REL_10DB;
         2'h3:    step_of = REL_14DB;
         default: step_of = '0;
      endcase
   endfunction

   // Offset in whole dB, so doubled onto the half-dB scale
   assign thr  = 10'($signed(base_thr_i)) + 10'($signed({abs_offset_i, 1'b0}));
   assign diff = 10'($signed(rssi_now_i)) - 10'($signed(rssi_prev_i));
   assign step = step_of(rel_step_i);

   always_ff @(posedge clk_i) begin
      if (rst_i || !rx_active_i) begin
         abs_cs <= 1'b0;
      end else if (fresh) begin
         if (10'($signed(rssi_now_i)) > thr) begin
            abs_cs <= 1'b1;
         end else if (10'($signed(rssi_now_i)) < thr - CS_HYST) begin
            abs_cs <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !rx_active_i || rel_step_i == 2'h0) begin
         rel_cs <= 1'b0;
      end else if (fresh) begin
         if (diff >= step) begin
            rel_cs <= 1'b1;
         end else if (diff <= -step) begin
            rel_cs <= 1'b0;
         end
      end
   end

   // Judge one cycle after the tick, once the new sample has landed
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fresh <= 1'b0;
      end else begin
         fresh <= tick_i;
      end
   end

   assign cs_o = abs_cs || rel_cs;
endmodule // carrier_sense

// >>> test/fe_model.sv
/*
 * Front-end and demodulator model: RSSI level and one-cycle events.
 * Assumes the bench calls its tasks right after a rising clk_i edge.
 */
`timescale 1ns/1ps
module fe_model (
   // Clock
   input  wire logic       clk_i,
   // Front-end outputs
   output logic      [7:0] rssi_o,
   output logic      [6:0] ev_o,
   output logic      [7:0] byte_o
);
   initial begin
      rssi_o = 8'h80;
      ev_o   = 7'h00;
      byte_o = 8'h00;
   end

   task automatic level(input logic [7:0] v);
      @(posedge clk_i);
      rssi_o <= v;
   endtask

   // Idle data shows the inverse so stale bytes never match
   task automatic pulse(input logic [6:0] p, input logic [7:0] b);
      @(posedge clk_i);
      ev_o   <= p;
      byte_o <= b;
      @(posedge clk_i);
      ev_o   <= 7'h00;
      byte_o <= ~b;
      repeat (2) @(posedge clk_i);
   endtask
endmodule // fe_model

// >>> test/rx_signal_qualifier_bench.sv
/*
 * Self-checking bench for the receive qualifier over Wishbone.
 * Assumes fe_model drives the front-end inputs.
 */
`timescale 1ns/1ps
module rx_signal_qualifier_bench;
   import rxq_pkg::*;
   logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
   logic [7:0]  adr = 0, lastb = 0;
   logic [31:0] dat = 0, rd_q;
   int          errors = 0, num_checks = 0, nwr = 0, cyc_cnt = 0, n0, tgap = 0, tper = 0;
   localparam int rssi_bias = 74;
   wire  [31:0] rdat;
   wire  [7:0]  rssi, rxb, fdat;
   wire  [6:0]  ev;
   wire  [2:0]  lna;
   wire  [1:0]  vga;
   wire         ack, fwr, filt, gpo0, gpo1;
   logic [6:0]  wrong [4] = '{7'h00, 7'h00, 7'h40, 7'h20};
   logic [6:0]  right [4] = '{7'h00, 7'h40, 7'h20, 7'h10};

   always #50 clk_i = ~clk_i;

   fe_model fe (.clk_i(clk_i), .rssi_o(rssi), .ev_o(ev), .byte_o(rxb));

   rx_signal_qualifier dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
      .rssi_raw_i(rssi), .sync15_i(ev[6]), .sync16_i(ev[5]), .sync30_i(ev[4]),
      .rx_byte_valid_i(ev[3]), .rx_byte_i(rxb), .pkt_end_i(ev[2]),
      .tx_underflow_i(ev[1]), .tx_done_i(ev[0]), .fifo_wr_o(fwr), .fifo_data_o(fdat),
      .filter_en_o(filt), .lna_gain_cap_o(lna), .vga_gain_cap_o(vga),
      .gpo0_o(gpo0), .gpo1_o(gpo1));

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      rd_q = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      wb(1'b0, a, 32'h0);
      chk(nm, rd_q, e);
   endtask

   task automatic cmd(input int b);
      wb(1'b1, OFS_COMMAND, 32'h1 << b);
   endtask

   // Two update periods so both samples are fresh
   task automatic tick;
      repeat (2 * RSSI_BASE_CYC + 10) @(posedge clk_i);
   endtask

   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   always @(posedge clk_i) begin
      if (fwr === 1'b1) begin
         nwr <= nwr + 1;
         lastb <= fdat;
      end
   end

   // Spacing of RSSI updates, for the update rate check
   always @(posedge clk_i) begin
      if (dut.rssi_tick === 1'b1) begin
         tper <= tgap + 1;
         tgap <= 0;
      end else begin
         tgap <= tgap + 1;
      end
   end

   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000) begin
         errors++;
         stop_test;
      end
   end

   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(OFS_MODEM_CONFIG2, 32'h2, "sync mode");
      rd(OFS_CS_BASE, 32'hb0, "threshold base");
      rd(OFS_RADIO_STATE, 32'h1, "idle state");
      rd(8'h3c, 32'h0, "unmapped");
      wb(1'b1, OFS_GAIN_CTRL2, 32'h1b);
      wb(1'b1, OFS_GAIN_CTRL2, 32'h1a);
      chk("gain caps", {lna, vga}, 5'h0b);
      for (int m = 0; m < 4; m++) begin
         wb(1'b1, OFS_MODEM_CONFIG2, m);
         cmd(CMD_RX);
         n0 = nwr;
         if (m > 0) begin
            fe.pulse(7'h08, 8'h11);
            fe.pulse(wrong[m], 8'h00);
            fe.pulse(7'h08, 8'h22);
            chk("gated writes", nwr, n0);
         end
         fe.pulse(right[m], 8'h00);
         chk("open", filt, 1'b1);
         fe.pulse(7'h08, 8'h50 + m);
         chk("qualified writes", nwr, n0 + 1);
         chk("written byte", lastb, 8'h50 + m);
         fe.pulse(7'h04, 8'h00);
      end
      wb(1'b1, OFS_PIN_CFG0, 32'he);
      wb(1'b1, OFS_PIN_CFG1, 32'h9);
      wb(1'b1, OFS_MODEM_CONFIG2, 32'h6);
      fe.level(8'h80);
      cmd(CMD_RX);
      tick;
      n0 = nwr;
      fe.pulse(7'h20, 8'h00);
      fe.pulse(7'h08, 8'h33);
      chk("carrier gated", nwr, n0);
      fe.level(8'hf0);
      tick;
      rd(OFS_PKT_STATE, 32'h1b, "status");
      fe.pulse(7'h20, 8'h00);
      fe.pulse(7'h08, 8'h44);
      chk("carrier open", nwr, n0 + 1);
      fe.level(8'h10);
      tick;
      rd(OFS_RSSI, 32'hf0, "frozen rssi");
      chk("rssi dbm", (int'(rd_q[7:0]) - (rd_q[7:0] >= 128 ? 256 : 0)) / 2 - rssi_bias, -82);
      wb(1'b1, OFS_RADIO_CTRL1, 32'h2);
      cmd(CMD_TX);
      rd(OFS_RADIO_STATE, 32'h2, "busy refuse");
      wb(1'b1, OFS_PKT_CTRL1_A, 32'h1);
      fe.pulse(7'h04, 8'h00);
      chk("status count", nwr, n0 + 2);
      chk("status byte", lastb, 8'h10);
      cmd(CMD_TX);
      rd(OFS_RADIO_STATE, 32'h3, "tx");
      fe.pulse(7'h02, 8'h00);
      rd(OFS_RADIO_STATE, 32'h5, "underflow");
      cmd(CMD_RX);
      wb(1'b1, OFS_RADIO_CTRL1, 32'h1);
      tick;
      chk("clear pin low", gpo1, 1'b0);
      cmd(CMD_FSTX);
      rd(OFS_RADIO_STATE, 32'h2, "rssi refuse");
      fe.level(8'h80);
      tick;
      chk("carrier pin", gpo0, 1'b0);
      chk("clear pin high", gpo1, 1'b1);
      rd(OFS_RADIO_STATE, 32'h2, "no self retry");
      cmd(CMD_FSTX);
      rd(OFS_RADIO_STATE, 32'h4, "synth ready");
      cmd(CMD_TX);
      fe.pulse(7'h01, 8'h00);
      rd(OFS_RADIO_STATE, 32'h1, "done idle");
      wb(1'b1, OFS_GAIN_CTRL1, 32'h9);
      wb(1'b1, OFS_GAIN_CTRL0, 32'h1);
      cmd(CMD_RX);
      fe.level(8'ha6);
      tick;
      tick;
      chk("rssi period", tper, RSSI_BASE_CYC << 1);
      chk("offset low", gpo0, 1'b1);
      wb(1'b1, OFS_GAIN_CTRL0, 32'h0);
      wb(1'b1, OFS_GAIN_CTRL1, 32'h27);
      tick;
      chk("offset high", gpo0, 1'b0);
      fe.level(8'hba);
      tick;
      chk("relative rise", gpo0, 1'b1);
      fe.level(8'ha6);
      tick;
      chk("relative fall", gpo0, 1'b0);
      stop_test;
   end
endmodule // rx_signal_qualifier_bench
